// File: hdl/csi_device.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module csi_device #(
  parameter int NUM_INPUTS = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  csi_link_if.dev link,
  input wire logic synth_lock_live,
  input wire logic atten_lock_live,
  input wire logic [NUM_INPUTS-1:0] input_activity_live,
  input wire logic reference_present_live,
  input wire logic holdover_live,
  input wire logic calib_active,
  input wire logic [1:0] selected_input_status
);

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, two stages
  localparam int NSYNC = NUM_INPUTS + 7;
  logic [NSYNC-1:0] pins_raw;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;

  assign pins_raw = {calib_active, selected_input_status, holdover_live,
                     reference_present_live, atten_lock_live, synth_lock_live,
                     input_activity_live};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      // all-good idle level, no false event latched after reset
      sync1_q <= '1;
      sync2_q <= '1;
    end else if (clk_en) begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end

  wire [NUM_INPUTS-1:0] act_s = sync2_q[NUM_INPUTS-1:0];
  wire synth_s = sync2_q[NUM_INPUTS];
  wire atten_s = sync2_q[NUM_INPUTS+1];
  wire ref_s = sync2_q[NUM_INPUTS+2];
  wire hold_s = sync2_q[NUM_INPUTS+3];
  wire [1:0] sel_s = sync2_q[NUM_INPUTS+5:NUM_INPUTS+4];
  wire calib_s = sync2_q[NUM_INPUTS+6];

  ////////////////////////////////////////////////////////////////////////////////
  // register access decode
  wire wr = link.req && link.we;
  wire rd = link.req && !link.we;
  wire wr_en_a = wr && (link.addr == csi_pkg::ADDR_IRQ_EN_A);
  wire wr_en_b = wr && (link.addr == csi_pkg::ADDR_IRQ_EN_B);
  wire wr_st_a = wr && (link.addr == csi_pkg::ADDR_STICKY_A);
  wire wr_st_b = wr && (link.addr == csi_pkg::ADDR_STICKY_B);

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt enables
  logic synth_en_q;
  logic atten_en_q;
  logic [NUM_INPUTS-1:0] los_en_q;
  logic ref_en_q;
  logic hold_en_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      synth_en_q <= csi_pkg::EN_RESET;
      atten_en_q <= csi_pkg::EN_RESET;
      los_en_q <= '0;
      ref_en_q <= csi_pkg::EN_RESET;
      hold_en_q <= csi_pkg::EN_RESET;
    end else if (clk_en) begin
      if (wr_en_a) begin
        synth_en_q <= link.wdata[csi_pkg::BIT_SYNTH];
        atten_en_q <= link.wdata[csi_pkg::BIT_ATTEN];
        los_en_q <= link.wdata[csi_pkg::BIT_LOS_LO +: NUM_INPUTS];
      end
      if (wr_en_b) begin
        ref_en_q <= link.wdata[csi_pkg::BIT_REF];
        hold_en_q <= link.wdata[csi_pkg::BIT_HOLD];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // event latches, high = event seen; set beats clear
  logic synth_ev_q;
  logic atten_ev_q;
  logic [NUM_INPUTS-1:0] los_ev_q;
  logic ref_ev_q;
  logic hold_ev_q;
  logic synth_ev_d;
  logic atten_ev_d;
  logic [NUM_INPUTS-1:0] los_ev_d;
  logic ref_ev_d;
  logic hold_ev_d;

  wire clr_synth = wr_st_a && link.wdata[csi_pkg::BIT_SYNTH];
  wire clr_atten = wr_st_a && link.wdata[csi_pkg::BIT_ATTEN];
  wire clr_ref = wr_st_b && link.wdata[csi_pkg::BIT_REF];
  wire clr_hold = wr_st_b && link.wdata[csi_pkg::BIT_HOLD];

  assign synth_ev_d = (synth_ev_q && !clr_synth) || !synth_s;
  assign atten_ev_d = (atten_ev_q && !clr_atten) || !atten_s;
  assign ref_ev_d = (ref_ev_q && !clr_ref) || !ref_s;
  assign hold_ev_d = (hold_ev_q && !clr_hold) || !hold_s;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_los
      wire clr_los = wr_st_a && link.wdata[csi_pkg::BIT_LOS_LO + gi];
      assign los_ev_d[gi] = (los_ev_q[gi] && !clr_los) || !act_s[gi];
    end
  endgenerate

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      synth_ev_q <= csi_pkg::EVENT_RESET;
      atten_ev_q <= csi_pkg::EVENT_RESET;
      los_ev_q <= '0;
      ref_ev_q <= csi_pkg::EVENT_RESET;
      hold_ev_q <= csi_pkg::EVENT_RESET;
    end else if (clk_en) begin
      synth_ev_q <= synth_ev_d;
      atten_ev_q <= atten_ev_d;
      los_ev_q <= los_ev_d;
      ref_ev_q <= ref_ev_d;
      hold_ev_q <= hold_ev_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt pin, active low
  wire irq_any = (synth_en_q && synth_ev_q)
              || (atten_en_q && atten_ev_q)
              || (|(los_en_q & los_ev_q))
              || (ref_en_q && ref_ev_q)
              || (hold_en_q && hold_ev_q);
  logic irq_low_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_low_q <= 1'h1;
    end else if (clk_en) begin
      irq_low_q <= !irq_any;
    end
  end

  assign link.irq_out_low = irq_low_q;

  ////////////////////////////////////////////////////////////////////////////////
  // read mux
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = csi_pkg::BYTE_RESET;
    case (link.addr)
      csi_pkg::ADDR_IRQ_EN_A: begin
        rd_mux[csi_pkg::BIT_SYNTH] = synth_en_q;
        rd_mux[csi_pkg::BIT_ATTEN] = atten_en_q;
        rd_mux[csi_pkg::BIT_LOS_LO +: NUM_INPUTS] = los_en_q;
      end
      csi_pkg::ADDR_IRQ_EN_B: begin
        rd_mux[csi_pkg::BIT_REF] = ref_en_q;
        rd_mux[csi_pkg::BIT_HOLD] = hold_en_q;
      end
      csi_pkg::ADDR_STICKY_A: begin
        rd_mux[csi_pkg::BIT_SYNTH] = !synth_ev_q;
        rd_mux[csi_pkg::BIT_ATTEN] = !atten_ev_q;
        rd_mux[csi_pkg::BIT_LOS_LO +: NUM_INPUTS] = ~los_ev_q;
      end
      csi_pkg::ADDR_LIVE_A: begin
        rd_mux[csi_pkg::BIT_SEL_LO +: 2] = sel_s;
        rd_mux[csi_pkg::BIT_SYNTH] = synth_s;
        rd_mux[csi_pkg::BIT_ATTEN] = atten_s;
        rd_mux[csi_pkg::BIT_LOS_LO +: NUM_INPUTS] = act_s;
      end
      csi_pkg::ADDR_STICKY_B: begin
        rd_mux[csi_pkg::BIT_REF] = !ref_ev_q;
        rd_mux[csi_pkg::BIT_HOLD] = !hold_ev_q;
      end
      csi_pkg::ADDR_LIVE_B: begin
        rd_mux[csi_pkg::BIT_CALIB] = calib_s;
        rd_mux[csi_pkg::BIT_REF] = ref_s;
        rd_mux[csi_pkg::BIT_HOLD] = hold_s;
      end
      default: begin
        rd_mux = csi_pkg::BYTE_RESET;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // answer one cycle after each request
  logic ack_q;
  logic [7:0] rdata_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_q <= 1'h0;
      rdata_q <= csi_pkg::BYTE_RESET;
    end else if (clk_en) begin
      ack_q <= link.req;
      if (rd) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign link.ack = ack_q;
  assign link.rdata = rdata_q;

endmodule : csi_device

// File: hdl/csi_host.sv
`timescale 1ns/100ps
module csi_host (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  csi_link_if.host link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic host_irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // apb slave, one access cycle per transfer
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  wire setup = psel && !penable && !pready_q;
  wire hit_cmd = (paddr == csi_pkg::APB_CMD);
  wire hit_st = (paddr == csi_pkg::APB_STATUS);
  wire commit = psel && penable && pready_q;
  wire busy;
  wire cmd_go = commit && pwrite && hit_cmd && !busy;
  wire rejected = commit && pwrite && hit_cmd && busy;

  ////////////////////////////////////////////////////////////////////////////////
  // irq pin synchroniser
  logic irq_s1_q;
  logic irq_s2_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_s1_q <= 1'h1;
      irq_s2_q <= 1'h1;
    end else if (clk_en) begin
      irq_s1_q <= link.irq_out_low;
      irq_s2_q <= irq_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // link transfer sequencer
  csi_pkg::csi_host_state_t state_q;
  logic req_q;
  logic we_q;
  logic [7:0] addr_q;
  logic [7:0] wdata_q;
  logic [7:0] last_rdata_q;
  logic err_q;
  logic irq_q;

  assign busy = (state_q != csi_pkg::CSI_IDLE);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= csi_pkg::CSI_IDLE;
      req_q <= 1'h0;
      we_q <= 1'h0;
      addr_q <= csi_pkg::BYTE_RESET;
      wdata_q <= csi_pkg::BYTE_RESET;
      last_rdata_q <= csi_pkg::BYTE_RESET;
      err_q <= 1'h0;
      irq_q <= 1'h0;
    end else if (clk_en) begin
      irq_q <= !irq_s2_q;
      if (rejected) begin
        err_q <= 1'h1;
      end else if (cmd_go) begin
        err_q <= 1'h0;
      end
      case (state_q)
        csi_pkg::CSI_IDLE: begin
          if (cmd_go) begin
            req_q <= 1'h1;
            we_q <= pwdata[csi_pkg::CMD_WRITE];
            addr_q <= pwdata[csi_pkg::CMD_ADDR_LO +: 8];
            wdata_q <= pwdata[csi_pkg::CMD_WDATA_LO +: 8];
            state_q <= csi_pkg::CSI_REQ;
          end
        end
        csi_pkg::CSI_REQ: begin
          req_q <= 1'h0;
          state_q <= csi_pkg::CSI_WAIT;
        end
        csi_pkg::CSI_WAIT: begin
          if (link.ack) begin
            if (!we_q) begin
              last_rdata_q <= link.rdata;
            end
            state_q <= csi_pkg::CSI_IDLE;
          end
        end
        default: begin
          state_q <= csi_pkg::CSI_IDLE;
          req_q <= 1'h0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // apb answer
  logic [31:0] status_word;

  always_comb begin
    status_word = csi_pkg::WORD_RESET;
    status_word[csi_pkg::ST_BUSY] = busy;
    status_word[csi_pkg::ST_IRQ] = irq_q;
    status_word[csi_pkg::ST_ERR] = err_q;
    status_word[csi_pkg::ST_RDATA_LO +: 8] = last_rdata_q;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready_q <= 1'h0;
      pslverr_q <= 1'h0;
      prdata_q <= csi_pkg::WORD_RESET;
    end else if (clk_en) begin
      pready_q <= setup;
      pslverr_q <= setup && !hit_cmd && !hit_st;
      if (setup) begin
        prdata_q <= hit_st ? status_word : csi_pkg::WORD_RESET;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign host_irq = irq_q;
  assign link.req = req_q;
  assign link.we = we_q;
  assign link.addr = addr_q;
  assign link.wdata = wdata_q;

endmodule : csi_host

// File: inc/csi_link_if.sv
`timescale 1ns/100ps
interface csi_link_if;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;
  logic irq_out_low;
  modport dev (
    input req,
    input we,
    input addr,
    input wdata,
    output ack,
    output rdata,
    output irq_out_low
  );
  modport host (
    output req,
    output we,
    output addr,
    output wdata,
    input ack,
    input rdata,
    input irq_out_low
  );
endinterface : csi_link_if

// File: inc/csi_pkg.sv
package csi_pkg;
  // device register byte addresses
  localparam logic [7:0] ADDR_IRQ_EN_A = 8'h68;
  localparam logic [7:0] ADDR_IRQ_EN_B = 8'h69;
  localparam logic [7:0] ADDR_STICKY_A = 8'h6C;
  localparam logic [7:0] ADDR_LIVE_A = 8'h6D;
  localparam logic [7:0] ADDR_STICKY_B = 8'h6E;
  localparam logic [7:0] ADDR_LIVE_B = 8'h6F;
  // field positions, group A registers
  localparam int BIT_LOS_LO = 0;
  localparam int BIT_ATTEN = 4;
  localparam int BIT_SYNTH = 5;
  localparam int BIT_SEL_LO = 6;
  // field positions, group B registers
  localparam int BIT_HOLD = 0;
  localparam int BIT_REF = 1;
  localparam int BIT_CALIB = 2;
  // reset values
  localparam logic EN_RESET = 1'h0;
  localparam logic EVENT_RESET = 1'h0;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // controller registers on the apb side
  localparam logic [7:0] APB_CMD = 8'h00;
  localparam logic [7:0] APB_STATUS = 8'h04;
  localparam int CMD_WDATA_LO = 0;
  localparam int CMD_ADDR_LO = 8;
  localparam int CMD_WRITE = 16;
  localparam int ST_BUSY = 0;
  localparam int ST_IRQ = 1;
  localparam int ST_ERR = 2;
  localparam int ST_RDATA_LO = 8;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  // link answer arrives one cycle after the request
  localparam int LINK_ANSWER_CYCLES = 1;
  typedef enum logic [1:0] {
    CSI_IDLE = 2'b00,
    CSI_REQ = 2'b01,
    CSI_WAIT = 2'b10
  } csi_host_state_t;
endpackage : csi_pkg

// File: verification/csi_asserts.sv
`timescale 1ns/100ps
module csi_asserts (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic [7:0] rdata,
  input wire logic irq_out_low
);
  logic [5:0] en_a_q;
  logic [1:0] en_b_q;
  wire rd_req = req && !we;
  wire wr_a = req && we && addr == csi_pkg::ADDR_IRQ_EN_A;
  wire wr_b = req && we && addr == csi_pkg::ADDR_IRQ_EN_B;
  wire en_any = |{en_a_q, en_b_q};
  // shadow of the enable registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      en_a_q <= 6'h00;
      en_b_q <= 2'h0;
    end else begin
      en_a_q <= wr_a ? wdata[5:0] : en_a_q;
      en_b_q <= wr_b ? wdata[1:0] : en_b_q;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_ack_after_req: assert property (req |=> ack)
    else $error("no ack after request");
  chk_ack_one_cycle: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  chk_ack_has_cause: assert property (ack |-> $past(req))
    else $error("ack without request");
  chk_en_a_read: assert property (rd_req && addr == 8'h68 |=> rdata == {2'h0, en_a_q})
    else $error("enable group a read mismatch");
  chk_en_b_read: assert property (rd_req && addr == 8'h69 |=> rdata == {6'h0, en_b_q})
    else $error("enable group b read mismatch");
  chk_sticky_a_resv: assert property (rd_req && addr == 8'h6C |=> rdata[7:6] == 2'h0)
    else $error("sticky group a reserved bits set");
  chk_sticky_b_resv: assert property (rd_req && addr == 8'h6E |=> rdata[7:2] == 6'h00)
    else $error("sticky group b reserved bits set");
  chk_live_b_resv: assert property (rd_req && addr == 8'h6F |=> rdata[7:3] == 5'h00)
    else $error("live group b reserved bits set");
  chk_irq_needs_en: assert property (!irq_out_low |-> en_any || $past(en_any) ||
    $past(en_any, 2))
    else $error("interrupt pin low with no enable set");
  cover property (wr_a ##1 ack);
  cover property ($fell(irq_out_low));
  cover property ($rose(irq_out_low));
endmodule : csi_asserts

// File: verification/tb.sv
`timescale 1ns/100ps
module tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, calib = 1'b0, pend_rd = 1'b0, ce = 1'b1;
  logic pready, pslverr, host_irq, perr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [1:0] sel = 2'h0;
  logic [7:0] good = 8'hFF, en = 8'h00, stk = 8'hFF;
  logic [7:0] exp_q[$];
  int n_errors = 0, total_checks = 0, cyc = 0;
  always #2.5 clk = ~clk;
  csi_link_if link_if();
  csi_device csi_device_inst (.clk(clk), .sys_rst(sys_rst), .clk_en(ce), .link(link_if),
    .synth_lock_live(good[5]), .atten_lock_live(good[4]), .input_activity_live(good[3:0]),
    .reference_present_live(good[6]), .holdover_live(good[7]), .calib_active(calib),
    .selected_input_status(sel));
  csi_host csi_host_inst (.clk(clk), .sys_rst(sys_rst), .clk_en(ce), .link(link_if),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .host_irq(host_irq));
  csi_asserts csi_asserts_inst (.clk(clk), .sys_rst(sys_rst), .req(link_if.req),
    .we(link_if.we), .addr(link_if.addr), .wdata(link_if.wdata), .ack(link_if.ack),
    .rdata(link_if.rdata), .irq_out_low(link_if.irq_out_low));
  //////////////////////////////////////////////////////////////////////////////
  task complete_run;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  task check(input logic [31:0] v, input logic [31:0] e);
    total_checks++;
    if (v !== e) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, v, e);
    end
  endtask : check
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task dev(input logic w, input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, csi_pkg::APB_CMD, {15'h0, w, a, d});
    r = 32'h1;
    while (r[csi_pkg::ST_BUSY] !== 1'b0) apb(1'b0, csi_pkg::APB_STATUS, 32'h0);
  endtask : dev
  task rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    dev(1'b0, a, 8'h00);
    check({24'h0, r[csi_pkg::ST_RDATA_LO +: 8]}, {24'h0, e});
  endtask : rd
  task rd_all;
    rd(8'h68, {2'h0, en[5:0]});
    rd(8'h69, {6'h0, en[6], en[7]});
    rd(8'h6C, {2'h0, stk[5:0]});
    rd(8'h6D, {sel, good[5:0]});
    rd(8'h6E, {6'h0, stk[6], stk[7]});
    rd(8'h6F, {5'h0, calib, good[6], good[7]});
    check({31'h0, host_irq}, {31'h0, |(~stk & en)});
  endtask : rd_all
  task put_en(input logic [7:0] m);
    en = m;
    dev(1'b1, 8'h68, {2'h0, m[5:0]});
    dev(1'b1, 8'h69, {6'h0, m[6], m[7]});
  endtask : put_en
  task set_good(input logic [7:0] g);
    @(posedge clk);
    good <= g;
    repeat (12) @(posedge clk);
    stk = stk & g;
  endtask : set_good
  task clr(input logic [7:0] m);
    dev(1'b1, 8'h6C, {2'h0, m[5:0]});
    dev(1'b1, 8'h6E, {6'h0, m[6], m[7]});
    stk = (stk | m) & good;
    repeat (6) @(posedge clk);
  endtask : clr
  //////////////////////////////////////////////////////////////////////////////
  // oldest note matched against each link read answer
  always @(posedge clk) begin
    if (link_if.req === 1'b1) pend_rd <= !link_if.we;
    if (link_if.ack === 1'b1 && pend_rd) begin
      if (exp_q.size() == 0) check(32'h1, 32'h0);
      else check({24'h0, link_if.rdata}, {24'h0, exp_q.pop_front()});
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      complete_run();
    end
  end
  initial begin
    void'($urandom(32'h8E7E3CF6));
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    rd_all();
    rd(8'h70, 8'h00);
    apb(1'b0, 8'h08, 32'h0);
    check({31'h0, perr}, 32'h1);
    $display("test reset values done");
    for (int i = 0; i < 16; i++) begin
      put_en(i[0] ? (8'h01 << i[3:1]) : 8'h00);
      set_good(~(8'h01 << i[3:1]));
      rd_all();
      set_good(8'hFF);
      clr(8'h01 << i[3:1]);
      rd_all();
    end
    $display("test single sources done");
    put_en(8'hFF);
    set_good(8'hD9);
    clr(8'hFF);
    rd_all();
    set_good(8'hFF);
    clr(8'h02);
    rd_all();
    clr(8'hFF);
    rd_all();
    $display("test pending sources done");
    for (int k = 0; k < 8; k++) begin
      sel <= k[1:0];
      calib <= 1'($urandom);
      put_en(8'($urandom));
      set_good(8'($urandom));
      rd_all();
      set_good(8'hFF);
      clr(8'hFF);
      rd_all();
    end
    $display("test random mix done");
    put_en(8'h3C);
    set_good(8'h00);
    @(posedge clk);
    sys_rst <= 1'b1;
    good <= 8'hFF;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    en = 8'h00;
    stk = 8'hFF;
    rd_all();
    $display("test second reset done");
    // frozen block must not see the lost inputs
    @(posedge clk);
    ce <= 1'b0;
    good <= 8'h00;
    repeat (12) @(posedge clk);
    good <= 8'hFF;
    repeat (2) @(posedge clk);
    ce <= 1'b1;
    repeat (6) @(posedge clk);
    rd_all();
    $display("test clock enable done");
    complete_run();
  end
endmodule : tb
